// file: common/ibr_pkg.sv
/*
  Constants for the instrument bus remote interface: register map, bus
  command codes, terminator characters and reset values.
  Assumes a single 100 MHz clock and an 8-bit register port.
*/
package ibr_pkg;

  // ----------------------------------------------------------------
  // Register map (8-bit data, word index)
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_ADDR = 3'h0;
  localparam logic [2:0] REG_TERM = 3'h1;
  localparam logic [2:0] REG_SRE = 3'h2;
  localparam logic [2:0] REG_STB = 3'h3;
  localparam logic [2:0] REG_STATE = 3'h4;
  localparam logic [2:0] REG_RESP = 3'h5;
  localparam logic [2:0] REG_QCHAR = 3'h6;
  localparam logic [2:0] REG_MSG = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_MIN = 5'h01;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_RST = 5'h0c;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] STB_MASK = 8'hbc;
  localparam int STB_RQS = 6;
  localparam int MSG_MAX = 64;

  // ----------------------------------------------------------------
  // Terminator choices and characters
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TERM_CRLF, TERM_LFCR, TERM_LF, TERM_EOI} ibr_term_e;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_STAR = 8'h2a;

  // ----------------------------------------------------------------
  // Multiline command bytes (sent with the attention line low)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_LLO = 8'h11;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;

endpackage

// file: core/ibr_remote.sv
/*
  Remote interface front end: bus addressing, terminators, remote/local
  and lockout, bus clear commands, service request, serial poll and
  message string checks, with an 8-bit register port.
  Assumes bus bytes arrive already handshaken, one strobe per byte,
  and that all inputs are synchronous to clk_sys_i.
*/
// Design decisions made here: the register addresses and the plain strobed port.
// What this block does
// - Bus address 1 to 30, reset to 12
// - Four terminator choices, CR LF default
// - Local key toggles remote and local
// - Remote shows indicator, blocks keypad input
// - REN assertion enters remote state
// - IFC abandons any bus transaction
// - Device drives SRQ to request service
// - LLO locks out front panel controls
// - DCL clears interface activity to idle
// - Addressed commands need our listen address
// - SDC clears only when listen addressed
// - GTL while addressed returns to local
// - SPE then talk returns status; SPD ends
// - Common commands start asterisk, queries question
// - Chained commands separated by semicolons
// - Every string ends with the terminator
// - Query answered only once talk addressed
// - Only the most recent query answered
// - Status byte reports six bits, polled
// - Serial poll completion clears status bits
module ibr_remote #(
  parameter int MSG_LEN = ibr_pkg::MSG_MAX
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] bus_byte_i,
  input wire logic bus_vld_i,
  input wire logic atn_n_i,
  input wire logic eoi_i,
  input wire logic ren_i,
  input wire logic ifc_i,
  output logic srq_o,
  output logic srq_oe_o,
  output logic [7:0] tx_byte_o,
  output logic tx_vld_o,
  output logic tx_eoi_o,
  input wire logic tx_rdy_i,
  input wire logic local_key_i,
  input wire logic [7:0] key_i,
  input wire logic key_vld_i,
  output logic [7:0] key_o,
  output logic key_vld_o,
  output logic remote_ind_o,
  output logic lockout_o,
  input wire logic [7:0] evt_i
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_T1, TX_T2} ibr_tx_e;
  ibr_tx_e tx_st_r, tx_st_nxt;
  logic [4:0] addr_r;
  logic [1:0] term_r;
  logic [7:0] sre_r, stb_r, resp_r, qchar_r, prev_r;
  logic remote_r, llo_r, lad_r, tad_r, spoll_r, ren_q_r;
  logic qpend_r, qseen_r, cur_q_r, first_r, ovf_r, star_r, semi_r, msgdone_r;
  logic [6:0] len_r;
  logic poll_byte_r;

  // ----------------------------------------------------------------
  // Byte classification
  // ----------------------------------------------------------------
  wire cmd_byte = bus_vld_i & ~atn_n_i;
  wire dat_byte = bus_vld_i & atn_n_i & lad_r;
  wire [2:0] grp = bus_byte_i[7:5];
  wire my_addr = bus_byte_i[4:0] == addr_r;
  wire is_lad = cmd_byte & grp == ibr_pkg::GRP_LISTEN & my_addr;
  wire is_tad = cmd_byte & grp == ibr_pkg::GRP_TALK & my_addr;
  wire oth_tad = cmd_byte & grp == ibr_pkg::GRP_TALK & ~my_addr & bus_byte_i != ibr_pkg::CMD_UNT;
  wire is_unl = cmd_byte & bus_byte_i == ibr_pkg::CMD_UNL;
  wire is_unt = cmd_byte & bus_byte_i == ibr_pkg::CMD_UNT;
  wire is_llo = cmd_byte & bus_byte_i == ibr_pkg::CMD_LLO;
  wire is_dcl = cmd_byte & bus_byte_i == ibr_pkg::CMD_DCL;
  wire is_spe = cmd_byte & bus_byte_i == ibr_pkg::CMD_SPE;
  wire is_spd = cmd_byte & bus_byte_i == ibr_pkg::CMD_SPD;
  wire is_sdc = cmd_byte & lad_r & bus_byte_i == ibr_pkg::CMD_SDC;
  wire is_gtl = cmd_byte & lad_r & bus_byte_i == ibr_pkg::CMD_GTL;
  wire dev_clr = is_dcl | is_sdc;

  // Terminator detection for the selected choice
  wire term_hit = (term_r == ibr_pkg::TERM_CRLF) ? (prev_r == ibr_pkg::CH_CR && bus_byte_i == ibr_pkg::CH_LF) :
                  (term_r == ibr_pkg::TERM_LFCR) ? (prev_r == ibr_pkg::CH_LF && bus_byte_i == ibr_pkg::CH_CR) :
                  (term_r == ibr_pkg::TERM_LF) ? (bus_byte_i == ibr_pkg::CH_LF) : eoi_i;
  wire is_qm = bus_byte_i == ibr_pkg::CH_QM;
  wire is_semi = bus_byte_i == ibr_pkg::CH_SEMI;
  wire msg_end = dat_byte & term_hit;

  // Status byte with request bit merged in
  wire [7:0] stb_live = stb_r & ibr_pkg::STB_MASK;
  wire rqs = |(stb_live & sre_r) & sre_r[ibr_pkg::STB_RQS];
  wire [7:0] stb_view = stb_live | ({7'h00, rqs} << ibr_pkg::STB_RQS);
  wire tx_take = tx_vld_o & tx_rdy_i;
  wire poll_done = tx_take & poll_byte_r;
  wire abort = ifc_i | dev_clr;
  wire wr_addr_ok = reg_wdata_i[4:0] >= ibr_pkg::ADDR_MIN && reg_wdata_i[4:0] <= ibr_pkg::ADDR_MAX;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Out of range addresses are dropped so the bus never sees 0 or 31
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r <= ibr_pkg::ADDR_RST;
      term_r <= ibr_pkg::TERM_CRLF;
      sre_r <= ibr_pkg::SRE_RST;
      resp_r <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ibr_pkg::REG_ADDR && wr_addr_ok) addr_r <= reg_wdata_i[4:0];
      if (reg_addr_i == ibr_pkg::REG_TERM) term_r <= reg_wdata_i[1:0];
      if (reg_addr_i == ibr_pkg::REG_SRE) sre_r <= reg_wdata_i;
      if (reg_addr_i == ibr_pkg::REG_RESP) resp_r <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Status byte: events set, a finished poll clears, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stb_r <= 8'h00;
    end else begin
      stb_r <= ((poll_done ? 8'h00 : stb_r) | evt_i) & ibr_pkg::STB_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Remote, local and lockout
  // ----------------------------------------------------------------
  // Lockout holds the local key off; losing REN releases both states
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      remote_r <= 1'b0;
      llo_r <= 1'b0;
      ren_q_r <= 1'b0;
    end else begin
      ren_q_r <= ren_i;
      if (!ren_i && ren_q_r) begin
        remote_r <= 1'b0;
        llo_r <= 1'b0;
      end else begin
        if (is_llo) llo_r <= 1'b1;
        if (ren_i && !ren_q_r) remote_r <= 1'b1;
        else if (is_gtl) remote_r <= 1'b0;
        else if (local_key_i && !llo_r) remote_r <= ~remote_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Addressing and serial poll mode
  // ----------------------------------------------------------------
  // Talk and listen exclude each other, as a basic talker and listener
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lad_r <= 1'b0;
      tad_r <= 1'b0;
      spoll_r <= 1'b0;
    end else if (ifc_i) begin
      lad_r <= 1'b0;
      tad_r <= 1'b0;
      spoll_r <= 1'b0;
    end else begin
      if (is_lad) lad_r <= 1'b1;
      else if (is_unl || is_tad) lad_r <= 1'b0;
      if (is_tad) tad_r <= 1'b1;
      else if (is_unt || oth_tad || is_lad) tad_r <= 1'b0;
      if (is_spe) spoll_r <= 1'b1;
      else if (is_spd || dev_clr) spoll_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Message string parser
  // ----------------------------------------------------------------
  // Length, chaining and query placement are checked as characters arrive
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_r <= 8'h00;
      len_r <= 7'h00;
      first_r <= 1'b1;
      cur_q_r <= 1'b0;
      qseen_r <= 1'b0;
      ovf_r <= 1'b0;
      star_r <= 1'b0;
      semi_r <= 1'b0;
      qchar_r <= 8'h00;
    end else if (abort) begin
      prev_r <= 8'h00;
      len_r <= 7'h00;
      first_r <= 1'b1;
      cur_q_r <= 1'b0;
      qseen_r <= 1'b0;
    end else if (dat_byte) begin
      prev_r <= bus_byte_i;
      if (msg_end) begin
        len_r <= 7'h00;
        first_r <= 1'b1;
        cur_q_r <= 1'b0;
        qseen_r <= 1'b0;
        semi_r <= 1'b0;
      end else begin
        len_r <= len_r + 7'h01;
        if (len_r >= 7'(MSG_LEN)) ovf_r <= 1'b1;
        if (first_r) begin
          qchar_r <= bus_byte_i;
          star_r <= bus_byte_i == ibr_pkg::CH_STAR;
        end
        first_r <= is_semi;
        if (is_semi) semi_r <= 1'b1;
        if (is_semi && cur_q_r) ovf_r <= 1'b1;
        if (is_qm) cur_q_r <= 1'b1;
        if (is_qm) qseen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending query: newest finished query replaces any older one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qpend_r <= 1'b0;
      msgdone_r <= 1'b0;
    end else if (abort) begin
      qpend_r <= 1'b0;
      msgdone_r <= 1'b0;
    end else begin
      if (msg_end && (qseen_r || is_qm)) qpend_r <= 1'b1;
      else if (tx_st_r == ibr_tx_e'(TX_DATA) && tx_take) qpend_r <= 1'b0;
      if (msg_end) msgdone_r <= 1'b1;
      else if (reg_rd_i && reg_addr_i == ibr_pkg::REG_MSG) msgdone_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Talker: poll byte, or response and terminator
  // ----------------------------------------------------------------
  wire can_resp = tad_r & ~spoll_r & qpend_r;
  wire can_poll = tad_r & spoll_r & ~tx_vld_o;
  wire eoi_mode = term_r == ibr_pkg::TERM_EOI;
  wire two_ch = term_r == ibr_pkg::TERM_CRLF || term_r == ibr_pkg::TERM_LFCR;
  wire [7:0] t1_ch = term_r == ibr_pkg::TERM_LFCR ? ibr_pkg::CH_LF :
                     term_r == ibr_pkg::TERM_LF ? ibr_pkg::CH_LF : ibr_pkg::CH_CR;
  wire [7:0] t2_ch = term_r == ibr_pkg::TERM_LFCR ? ibr_pkg::CH_CR : ibr_pkg::CH_LF;

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      TX_IDLE: if (can_resp) tx_st_nxt = TX_DATA;
      TX_DATA: if (tx_take) tx_st_nxt = eoi_mode ? TX_IDLE : TX_T1;
      TX_T1: if (tx_take) tx_st_nxt = two_ch ? TX_T2 : TX_IDLE;
      TX_T2: if (tx_take) tx_st_nxt = TX_IDLE;
      default: tx_st_nxt = TX_IDLE;
    endcase
  end

  // Byte out register; abort drops the byte in flight
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_r <= TX_IDLE;
      tx_vld_o <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_eoi_o <= 1'b0;
      poll_byte_r <= 1'b0;
    end else if (abort || !tad_r) begin
      tx_st_r <= TX_IDLE;
      tx_vld_o <= 1'b0;
      tx_eoi_o <= 1'b0;
      poll_byte_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_st_r == TX_IDLE && can_poll) begin
        tx_vld_o <= 1'b1;
        tx_byte_o <= stb_view;
        tx_eoi_o <= 1'b0;
        poll_byte_r <= 1'b1;
      end else if (tx_st_nxt != tx_st_r || (tx_st_r == TX_IDLE && tx_take)) begin
        tx_vld_o <= tx_st_nxt != TX_IDLE;
        tx_byte_o <= tx_st_nxt == TX_DATA ? resp_r : tx_st_nxt == TX_T1 ? t1_ch : t2_ch;
        tx_eoi_o <= (tx_st_nxt == TX_DATA && eoi_mode) || (tx_st_nxt == TX_T1 && !two_ch) || tx_st_nxt == TX_T2;
        poll_byte_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins, panel and register read data
  // ----------------------------------------------------------------
  wire [7:0] state_v = {ovf_r, star_r, semi_r, qpend_r, spoll_r, tad_r, lad_r, remote_r};
  wire [7:0] rd_mux = reg_addr_i == ibr_pkg::REG_ADDR ? {3'h0, addr_r} :
                      reg_addr_i == ibr_pkg::REG_TERM ? {6'h00, term_r} :
                      reg_addr_i == ibr_pkg::REG_SRE ? sre_r :
                      reg_addr_i == ibr_pkg::REG_STB ? stb_view :
                      reg_addr_i == ibr_pkg::REG_STATE ? state_v :
                      reg_addr_i == ibr_pkg::REG_RESP ? resp_r :
                      reg_addr_i == ibr_pkg::REG_QCHAR ? qchar_r : {7'h00, msgdone_r};

  // SRQ is open drain: low level, enable while requesting service
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srq_o <= 1'b0;
      srq_oe_o <= 1'b0;
      remote_ind_o <= 1'b0;
      lockout_o <= 1'b0;
      key_o <= 8'h00;
      key_vld_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      srq_oe_o <= rqs & ~poll_done;
      remote_ind_o <= remote_r;
      lockout_o <= llo_r;
      key_vld_o <= key_vld_i & ~remote_r;
      if (key_vld_i) key_o <= key_i;
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_addr_range;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      addr_r >= ibr_pkg::ADDR_MIN && addr_r <= ibr_pkg::ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("bus address out of range");

  property p_ren_remote;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ren_i && !ren_q_r ##1 ren_i |=> remote_ind_o;
  endproperty
  a_ren_remote: assert property (p_ren_remote) else $error("REN did not enter remote");

  property p_keypad_block;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      remote_r |=> !key_vld_o;
  endproperty
  a_keypad_block: assert property (p_keypad_block) else $error("keypad passed in remote");

  property p_ifc_abort;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      ifc_i |=> !tx_vld_o && !lad_r && !tad_r && !spoll_r;
  endproperty
  a_ifc_abort: assert property (p_ifc_abort) else $error("IFC left bus activity");

  property p_llo_key;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      llo_r && ren_i && !(ren_i && !ren_q_r) && !is_gtl && local_key_i |=> $stable(remote_r);
  endproperty
  a_llo_key: assert property (p_llo_key) else $error("local key acted under lockout");

  property p_sdc_unaddressed;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      cmd_byte && bus_byte_i == ibr_pkg::CMD_SDC && !lad_r && !ifc_i && qpend_r && !tad_r |=> qpend_r;
  endproperty
  a_sdc_unaddressed: assert property (p_sdc_unaddressed) else $error("SDC acted while unaddressed");

  property p_no_unasked_tx;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(tx_vld_o) |-> $past(tad_r);
  endproperty
  a_no_unasked_tx: assert property (p_no_unasked_tx) else $error("sent while not talk addressed");

  property p_poll_clears;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      poll_done && evt_i == 8'h00 |=> stb_r == 8'h00;
  endproperty
  a_poll_clears: assert property (p_poll_clears) else $error("poll left status bits");

  property p_srq_cause;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      srq_oe_o |-> $past(sre_r[ibr_pkg::STB_RQS]) && $past(|(stb_live & sre_r));
  endproperty
  a_srq_cause: assert property (p_srq_cause) else $error("SRQ without enabled status");

endmodule

// file: verification/ibr_ctrl_model.sv
/*
  Bus controller model: sends command and data bytes, drives REN and IFC,
  takes talk bytes with random stalls against a credit count.
  Assumes the remote interface clock and already handshaken bytes.
*/
module ibr_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic tx_vld_i,
  output logic [7:0] byte_o,
  output logic vld_o,
  output logic atn_n_o,
  output logic eoi_o,
  output logic ren_o,
  output logic ifc_o,
  output logic rdy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int credits = 0;
  int seed = 19769;

  // ------------------------------------------------------------
  // Bus side drivers
  // ------------------------------------------------------------
  initial begin
    byte_o = 8'h00;
    vld_o = 1'b0;
    atn_n_o = 1'b1;
    eoi_o = 1'b0;
    ren_o = 1'b0;
    ifc_o = 1'b0;
  end

  // Commands go out with attention low, data with it high
  task automatic send(input logic [7:0] b, input logic atn_n, input logic eoi);
    @(posedge clk_sys_i);
    byte_o <= b;
    vld_o <= 1'b1;
    atn_n_o <= atn_n;
    eoi_o <= eoi;
  endtask

  // Released data lines show the inverse, never a stale byte
  task automatic idle();
    @(posedge clk_sys_i);
    vld_o <= 1'b0;
    byte_o <= ~byte_o;
    eoi_o <= 1'b0;
    atn_n_o <= 1'b1;
  endtask

  task automatic set_ren(input logic v);
    @(posedge clk_sys_i);
    ren_o <= v;
  endtask

  task automatic pulse_ifc();
    @(posedge clk_sys_i);
    ifc_o <= 1'b1;
    @(posedge clk_sys_i);
    ifc_o <= 1'b0;
  endtask

  task automatic give(input int n);
    credits = credits + n;
  endtask

  // Listener takes one byte per credit, idles a cycle after each take
  initial rdy_o = 1'b0;
  always @(posedge clk_sys_i) begin
    if (tx_vld_i && rdy_o) begin
      credits <= credits - 1;
      rdy_o <= 1'b0;
    end else begin
      rdy_o <= (credits > 0) && (($random(seed) & 1) == 1);
    end
  end
endmodule

// file: verification/tb.sv
/*
  Self-checking bench for the remote interface: register port master,
  keypad and event stimulus, expected-value queues and a monitor.
  Assumes the controller model on the bus side.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] key_i = 8'h00;
  logic [7:0] evt_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic local_key_i = 1'b0;
  logic key_vld_i = 1'b0;
  logic [7:0] reg_rdata_o, bus_byte_i, tx_byte_o, key_o, rk;
  logic bus_vld_i, atn_n_i, eoi_i, ren_i, ifc_i, tx_rdy_i, srq_o, srq_oe_o;
  logic tx_vld_o, tx_eoi_o, key_vld_o, remote_ind_o, lockout_o, rd_d;
  int mismatches = 0;
  int compares = 0;
  int seed = 19769;
  logic [17:0] rdq[$], txq[$], m, mt;

  always #5 clk_sys_i = ~clk_sys_i;

  ibr_remote u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .bus_byte_i(bus_byte_i), .bus_vld_i(bus_vld_i), .atn_n_i(atn_n_i), .eoi_i(eoi_i), .ren_i(ren_i),
    .ifc_i(ifc_i), .srq_o(srq_o), .srq_oe_o(srq_oe_o), .tx_byte_o(tx_byte_o), .tx_vld_o(tx_vld_o),
    .tx_eoi_o(tx_eoi_o), .tx_rdy_i(tx_rdy_i), .local_key_i(local_key_i), .key_i(key_i),
    .key_vld_i(key_vld_i), .key_o(key_o), .key_vld_o(key_vld_o), .remote_ind_o(remote_ind_o),
    .lockout_o(lockout_o), .evt_i(evt_i));
  ibr_ctrl_model u_ctrl (.clk_sys_i(clk_sys_i), .tx_vld_i(tx_vld_o), .byte_o(bus_byte_i),
    .vld_o(bus_vld_i), .atn_n_o(atn_n_i), .eoi_o(eoi_i), .ren_o(ren_i), .ifc_o(ifc_i), .rdy_o(tx_rdy_i));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  // Read data stand only in the cycle after the strobe; stray talk bytes fail
  initial rd_d = 1'b0;
  always @(posedge clk_sys_i) begin
    rd_d <= reg_rd_i;
    if (rd_d) begin
      m = rdq.pop_front();
      chk({1'b0, reg_rdata_o} & m[17:9], m[8:0]);
    end
    if (tx_vld_o && tx_rdy_i) begin
      mt = (txq.size() > 0) ? txq.pop_front() : {9'h1ff, ~{tx_eoi_o, tx_byte_o}};
      chk({tx_eoi_o, tx_byte_o} & mt[17:9], mt[8:0]);
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k = 8'hff);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rdq.push_back({1'b0, k, 1'b0, e & k});
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_ctrl.send(b, 1'b0, 1'b0);
    u_ctrl.idle();
  endtask

  // Whole message with the terminator of mode md
  task automatic msg(input string s, input int md);
    for (int i = 0; i < s.len(); i++) u_ctrl.send(s[i], 1'b1, md == 3 && i == s.len() - 1);
    if (md < 2) u_ctrl.send(md == 0 ? ibr_pkg::CH_CR : ibr_pkg::CH_LF, 1'b1, 1'b0);
    if (md != 3) u_ctrl.send(md == 1 ? ibr_pkg::CH_CR : ibr_pkg::CH_LF, 1'b1, 1'b0);
    u_ctrl.idle();
  endtask

  task automatic rmsg(input int n);
    for (int i = 0; i < n; i++) u_ctrl.send(8'h41 + 8'($unsigned($random(seed)) % 26), 1'b1, 1'b0);
    msg("", 0);
  endtask

  task automatic ex(input logic e, input logic [7:0] b, input logic [8:0] k = 9'h1ff);
    txq.push_back({k, k & {e, b}});
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && txq.size() > 0; i++) @(posedge clk_sys_i);
    pause(2);
    chk({8'h00, txq.size() == 0}, 9'h001);
  endtask

  task automatic pulse_key(input logic loc, input logic [7:0] code);
    @(posedge clk_sys_i);
    local_key_i <= loc;
    key_vld_i <= ~loc;
    key_i <= code;
    @(posedge clk_sys_i);
    local_key_i <= 1'b0;
    key_vld_i <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  initial begin
    logic [7:0] av[4] = '{8'h00, 8'h1f, 8'h1e, 8'h01};
    logic [7:0] ev[4] = '{8'h0c, 8'h0c, 8'h1e, 8'h01};
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(ibr_pkg::REG_ADDR, 8'h0c, 8'h1f);
    rd(ibr_pkg::REG_TERM, 8'h00, 8'h03);
    wr(ibr_pkg::REG_STB, 8'hff);
    rd(ibr_pkg::REG_STB, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ibr_pkg::REG_ADDR, av[i]);
      rd(ibr_pkg::REG_ADDR, ev[i], 8'h1f);
    end
    wr(ibr_pkg::REG_ADDR, 8'h1e);
    cmd(8'h2c);
    rd(ibr_pkg::REG_STATE, 8'h00, 8'h02);
    cmd(8'h3e);
    rd(ibr_pkg::REG_STATE, 8'h02, 8'h02);
    wr(ibr_pkg::REG_ADDR, 8'h0c);
    cmd(ibr_pkg::CMD_UNL);
    $display("test addressing end");
    // Remote, local key and keypad gating
    rk = 8'($random(seed));
    u_ctrl.set_ren(1'b1);
    pause(3);
    chk({8'h00, remote_ind_o}, 9'h001);
    pulse_key(1'b0, rk);
    chk({8'h00, key_vld_o}, 9'h000);
    u_ctrl.set_ren(1'b0);
    pulse_key(1'b0, rk);
    chk({key_vld_o, key_o}, {1'b1, rk});
    pulse_key(1'b1, 8'h00);
    pause(3);
    chk({8'h00, remote_ind_o}, 9'h001);
    pulse_key(1'b1, 8'h00);
    pause(3);
    chk({8'h00, remote_ind_o}, 9'h000);
    u_ctrl.set_ren(1'b1);
    cmd(ibr_pkg::CMD_LLO);
    pulse_key(1'b1, 8'h00);
    pause(3);
    chk({7'h00, lockout_o, remote_ind_o}, 9'h003);
    cmd(ibr_pkg::CMD_GTL);
    pause(3);
    chk({8'h00, remote_ind_o}, 9'h001);
    cmd(8'h2c);
    cmd(ibr_pkg::CMD_GTL);
    pause(3);
    chk({8'h00, remote_ind_o}, 9'h000);
    u_ctrl.set_ren(1'b0);
    pause(3);
    chk({8'h00, lockout_o}, 9'h000);
    $display("test remote end");
    // Query answered in every terminator mode, only once talk addressed
    wr(ibr_pkg::REG_RESP, rk);
    for (int md = 0; md < 4; md++) begin
      wr(ibr_pkg::REG_TERM, 8'(md));
      cmd(8'h2c);
      msg("Q?", md);
      pause(4);
      chk({8'h00, tx_vld_o}, 9'h000);
      ex(md == 3, rk);
      if (md < 2) ex(1'b0, md == 0 ? ibr_pkg::CH_CR : ibr_pkg::CH_LF);
      if (md != 3) ex(1'b1, md == 1 ? ibr_pkg::CH_CR : ibr_pkg::CH_LF);
      u_ctrl.give(md == 3 ? 1 : md == 2 ? 2 : 3);
      cmd(8'h4c);
      drain();
      chk({8'h00, tx_vld_o}, 9'h000);
      cmd(ibr_pkg::CMD_UNT);
    end
    wr(ibr_pkg::REG_TERM, 8'h00);
    cmd(8'h2c);
    msg("A?", 0);
    msg("B?", 0);
    rd(ibr_pkg::REG_MSG, 8'h01, 8'h01);
    rd(ibr_pkg::REG_MSG, 8'h00, 8'h01);
    rd(ibr_pkg::REG_QCHAR, 8'h42);
    ex(1'b0, rk);
    ex(1'b0, ibr_pkg::CH_CR);
    ex(1'b1, ibr_pkg::CH_LF);
    u_ctrl.give(3);
    cmd(8'h4c);
    drain();
    chk({8'h00, tx_vld_o}, 9'h000);
    cmd(ibr_pkg::CMD_UNT);
    cmd(8'h2c);
    msg("*A;X", 0);
    rd(ibr_pkg::REG_QCHAR, 8'h58);
    msg("*B", 0);
    rd(ibr_pkg::REG_QCHAR, ibr_pkg::CH_STAR);
    $display("test query end");
    // Clears drop a pending query; SDC needs the listen address
    msg("Z?", 0);
    cmd(ibr_pkg::CMD_DCL);
    rd(ibr_pkg::REG_STATE, 8'h00, 8'h10);
    cmd(8'h2c);
    msg("Z?", 0);
    cmd(ibr_pkg::CMD_UNL);
    cmd(ibr_pkg::CMD_SDC);
    rd(ibr_pkg::REG_STATE, 8'h10, 8'h10);
    cmd(8'h2c);
    cmd(ibr_pkg::CMD_SDC);
    rd(ibr_pkg::REG_STATE, 8'h00, 8'h10);
    msg("Z?", 0);
    u_ctrl.pulse_ifc();
    rd(ibr_pkg::REG_STATE, 8'h00, 8'h12);
    $display("test clear end");
    // Serial poll returns status then clears it
    wr(ibr_pkg::REG_SRE, 8'hff);
    @(posedge clk_sys_i);
    evt_i <= 8'h06;
    @(posedge clk_sys_i);
    evt_i <= 8'h00;
    pause(3);
    rd(ibr_pkg::REG_STB, 8'h44);
    chk({7'h00, srq_oe_o, srq_o}, 9'h002);
    cmd(ibr_pkg::CMD_SPE);
    ex(1'b0, 8'h44, 9'h0ff);
    u_ctrl.give(1);
    cmd(8'h4c);
    drain();
    cmd(ibr_pkg::CMD_SPD);
    cmd(ibr_pkg::CMD_UNT);
    pause(2);
    rd(ibr_pkg::REG_STB, 8'h00);
    chk({7'h00, srq_oe_o, tx_vld_o}, 9'h000);
    $display("test poll end");
    // String length and query placement
    cmd(8'h2c);
    rmsg(63);
    rd(ibr_pkg::REG_STATE, 8'h00, 8'h80);
    msg("A?;B", 0);
    rd(ibr_pkg::REG_STATE, 8'h80, 8'h80);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(ibr_pkg::REG_STATE, 8'h00);
    cmd(8'h2c);
    rmsg(66);
    rd(ibr_pkg::REG_STATE, 8'h80, 8'h80);
    pause(3);
    $display("test length end");
    wrap_up();
  end
endmodule
